//--- src/sbd_pkg.sv
// Constants and carrier types shared by the side bus and DMA handshake block.
package sbd_pkg;

  // ==========================================================================
  // Bus cycle timing
  // ==========================================================================
  localparam int SBD_CLK_NS = 100;  // Clock period in ns.
  localparam int SBD_STROBE_NS = 300;  // Least strobe width in ns.
  // Least strobe width in clock cycles, rounded up.
  localparam int SBD_STROBE_CYC = (SBD_STROBE_NS + SBD_CLK_NS - 1) / SBD_CLK_NS;

  // ==========================================================================
  // Boot ROM ranges, one enable bit each
  // ==========================================================================
  localparam int SBD_ROM_RANGES = 2;  // Number of decoded ROM ranges.
  localparam logic [23:0] SBD_ROM0_BASE = 24'h0f0000;  // Upper ROM range base.
  localparam logic [23:0] SBD_ROM1_BASE = 24'h0e0000;  // Lower ROM range base.
  localparam logic [23:0] SBD_ROM_MASK = 24'hff0000;  // Each range spans 64 KiB.

  // ==========================================================================
  // DMA channels and the shared channel-3 pins
  // ==========================================================================
  localparam int SBD_DMA_CH = 4;  // Number of DMA channels.
  localparam int SBD_SHARED_CH = 3;  // Channel whose pins double as GPIO.
  localparam int SBD_GPIO_REQ_PIN = 27;  // GPIO number shared with request 3.
  localparam int SBD_GPIO_GNT_PIN = 28;  // GPIO number shared with grant 3.
  // Direction after reset, bit 1 for pin 28, bit 0 for pin 27; 1 is output.
  localparam logic [1:0] SBD_GPIO_DIR_RESET = 2'h2;

  // ==========================================================================
  // Types
  // ==========================================================================
  // One processor-side bus cycle request.
  typedef struct packed {
    logic write;  // 1 for an I/O or memory write.
    logic [23:0] addr;  // Cycle address.
    logic [15:0] wdata;  // Write data, low byte used by the slave.
  } sbd_cyc_type;

  // Bus cycle sequencer states, one-hot.
  typedef enum logic [3:0] {
    SBD_ST_IDLE = 4'h1,
    SBD_ST_SETUP = 4'h2,
    SBD_ST_STROBE = 4'h4,
    SBD_ST_HOLD = 4'h8
  } sbd_state_type;

endpackage

//--- src/sbd_side_bus.sv
// Side bus master with boot ROM select, four-channel DMA grant and ready waits.
`timescale 1ns/1ns

// Function
// - Boot ROM select only for enabled ranges.
// - Grant low marks granted channel request.
// - Bus reset drives all grants high.
// - Request edges synchronised before use.
// - Low ready line inserts wait states.
// - Grant 3 shares pin with GPIO 28.
// - Request 3 shares pin with GPIO 27.
// - GPIO 28 defaults output, 27 input.
// - Read strobe makes slave drive data.
// - Write strobe makes slave latch low byte.
// - Bus reset drives both strobes high.
module sbd_side_bus
  import sbd_pkg::*;
#(
  parameter int STROBE_CYC = SBD_STROBE_CYC,
  parameter int LEN_W = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic cyc_valid,
  input wire sbd_cyc_type cyc_req,
  input wire logic [SBD_ROM_RANGES-1:0] rom_range_enable,
  output logic cyc_done,
  output logic [15:0] cyc_rdata,
  input wire logic dma_write,
  input wire logic [LEN_W-1:0] dma_len,
  input wire logic [15:0] dma_wdata,
  input wire logic [SBD_DMA_CH-2:0] dma_request,
  output logic [SBD_DMA_CH-2:0] dma_grant_n,
  output logic io_read_strobe_n,
  output logic io_write_strobe_n,
  output logic boot_rom_select_n,
  output logic [23:0] side_addr,
  input wire logic [15:0] side_data_bus_in,
  output logic [15:0] side_data_bus_out,
  output logic side_data_bus_oe,
  input wire logic channel_ready_in,
  output logic channel_ready_out,
  output logic channel_ready_oe,
  input wire logic gpio_mode,
  input wire logic gpio_dir_load,
  input wire logic [1:0] gpio_dir_value,
  input wire logic [1:0] gpio_out,
  output logic [1:0] gpio_in,
  input wire logic pin27_in,
  output logic pin27_out,
  output logic pin27_oe,
  input wire logic pin28_in,
  output logic pin28_out,
  output logic pin28_oe
);

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  // The strobe counter is four bits wide and must count at least one cycle.
  if (STROBE_CYC < 1 || STROBE_CYC > 15) begin : g_bad_strobe
    $error("STROBE_CYC must lie between 1 and 15");
  end
  if (LEN_W < 1 || LEN_W > 16) begin : g_bad_len
    $error("LEN_W must lie between 1 and 16");
  end

  localparam logic [3:0] STROBE_LAST = 4'(STROBE_CYC - 1);  // Counter load value.

  // ==========================================================================
  // Decode helpers
  // ==========================================================================
  // Returns 1 when the address hits an enabled boot ROM range.
  function automatic logic rom_hit(input logic [23:0] a,
                                   input logic [SBD_ROM_RANGES-1:0] en);
    rom_hit = (en[0] && ((a & SBD_ROM_MASK) == SBD_ROM0_BASE)) ||
              (en[1] && ((a & SBD_ROM_MASK) == SBD_ROM1_BASE));
  endfunction

  // ==========================================================================
  // Signals
  // ==========================================================================
  sbd_state_type st_r;  // Bus cycle sequencer state.
  logic [3:0] cnt_r;  // Remaining strobe cycles before ready is honoured.
  logic [SBD_DMA_CH-1:0] req_s1_r;  // First synchroniser stage, read by stage two only.
  logic [SBD_DMA_CH-1:0] req_s2_r;  // Synchronised requests.
  logic rdy_s1_r;  // First ready synchroniser stage.
  logic rdy_s2_r;  // Synchronised ready line.
  logic [SBD_DMA_CH-1:0] raw_req;  // Requests as seen at the pins.
  logic [SBD_DMA_CH-1:0] pend;  // Synchronised requests still eligible.
  logic [SBD_DMA_CH-1:0] grant_nxt_n;  // Next grant vector, active low.
  logic [SBD_DMA_CH-1:0] grant_n_r;  // Grant vector, active low.
  logic [LEN_W-1:0] left_r;  // Cycles left in the granted transfer.
  logic dma_act;  // Some channel is granted.
  logic dma_cyc_r;  // The current bus cycle belongs to the DMA transfer.
  logic wr_r;  // The current bus cycle writes.
  logic [1:0] dir_r;  // GPIO direction for pins 28 and 27.
  logic mode_r;  // Registered GPIO mode select.
  logic first_r;  // High in the first cycle after reset release.

  // The shared request pin feeds channel 3 only outside GPIO mode.
  assign raw_req = {pin27_in & ~gpio_mode, dma_request};
  assign pend = req_s2_r & {~gpio_mode, 3'h7};
  assign dma_act = ~&grant_n_r;
  assign dma_grant_n = grant_n_r[SBD_DMA_CH-2:0];

  // ==========================================================================
  // Synchronisers
  // ==========================================================================
  // Requests and ready arrive from other clock domains and pass two stages.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      req_s1_r <= '0;
      req_s2_r <= '0;
      rdy_s1_r <= 1'b1;
      rdy_s2_r <= 1'b1;
    end else begin
      req_s1_r <= raw_req;
      req_s2_r <= req_s1_r;
      rdy_s1_r <= channel_ready_in;
      rdy_s2_r <= rdy_s1_r;
    end
  end

  // ==========================================================================
  // DMA arbitration and grant
  // ==========================================================================
  // An idle bus grants the lowest pending channel; the grant stays put until
  // the count runs out or the request is withdrawn at the end of a cycle.
  always_comb begin
    grant_nxt_n = grant_n_r;
    if (st_r == SBD_ST_IDLE && !dma_act) begin
      for (int i = SBD_DMA_CH - 1; i >= 0; i--) begin
        if (pend[i]) begin
          grant_nxt_n = ~(4'h1 << i);
        end
      end
    end else if (st_r == SBD_ST_HOLD && dma_cyc_r) begin
      if (left_r <= 1 || !(|(pend & ~grant_n_r))) begin
        grant_nxt_n = '1;
      end
    end
    if (gpio_mode) begin
      grant_nxt_n[SBD_SHARED_CH] = 1'b1;
    end
  end

  // Grant and transfer count registers; the shared pin follows grant 3.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      grant_n_r <= '1;
      left_r <= '0;
    end else begin
      grant_n_r <= grant_nxt_n;
      if (st_r == SBD_ST_IDLE && !dma_act) begin
        left_r <= dma_len;
      end else if (st_r == SBD_ST_HOLD && dma_cyc_r) begin
        left_r <= left_r - 1'b1;
      end
    end
  end

  // ==========================================================================
  // Bus cycle sequencer
  // ==========================================================================
  // A granted channel is served before any processor cycle; the strobe lasts
  // its least width and then as long as the synchronised ready stays low.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_r <= SBD_ST_IDLE;
      cnt_r <= '0;
      dma_cyc_r <= 1'b0;
      wr_r <= 1'b0;
      io_read_strobe_n <= 1'b1;
      io_write_strobe_n <= 1'b1;
      boot_rom_select_n <= 1'b1;
      side_addr <= '0;
      side_data_bus_out <= '0;
      side_data_bus_oe <= 1'b0;
      cyc_done <= 1'b0;
      cyc_rdata <= '0;
    end else begin
      cyc_done <= 1'b0;
      unique case (st_r)
        SBD_ST_IDLE: begin
          if (dma_act) begin
            // The grant already selects the slave; no address is decoded.
            st_r <= SBD_ST_SETUP;
            dma_cyc_r <= 1'b1;
            wr_r <= dma_write;
            side_addr <= '0;
            side_data_bus_out <= dma_wdata;
            side_data_bus_oe <= dma_write;
          end else if (cyc_valid && pend == '0) begin
            st_r <= SBD_ST_SETUP;
            dma_cyc_r <= 1'b0;
            wr_r <= cyc_req.write;
            side_addr <= cyc_req.addr;
            side_data_bus_out <= cyc_req.wdata;
            side_data_bus_oe <= cyc_req.write;
            boot_rom_select_n <= ~rom_hit(cyc_req.addr, rom_range_enable);
          end
        end
        SBD_ST_SETUP: begin
          // Address and select settle one cycle before the strobe.
          st_r <= SBD_ST_STROBE;
          cnt_r <= STROBE_LAST;
          io_read_strobe_n <= wr_r;
          io_write_strobe_n <= ~wr_r;
        end
        SBD_ST_STROBE: begin
          if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
          end else if (rdy_s2_r) begin
            // Read data is taken while the strobe is still low.
            st_r <= SBD_ST_HOLD;
            cyc_rdata <= side_data_bus_in;
            io_read_strobe_n <= 1'b1;
            io_write_strobe_n <= 1'b1;
          end
          // Otherwise ready is low and the strobe stays asserted.
        end
        SBD_ST_HOLD: begin
          // One cycle of hold after the strobe closes the cycle.
          st_r <= SBD_ST_IDLE;
          boot_rom_select_n <= 1'b1;
          side_data_bus_oe <= 1'b0;
          cyc_done <= ~dma_cyc_r;
        end
      endcase
    end
  end

  // ==========================================================================
  // Shared GPIO pins
  // ==========================================================================
  // Direction register starts at its defaults and is reloaded on request.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dir_r <= SBD_GPIO_DIR_RESET;
      mode_r <= 1'b0;
      first_r <= 1'b1;
      gpio_in <= '0;
      pin27_out <= 1'b0;
      pin27_oe <= 1'b0;
      pin28_out <= 1'b1;
      pin28_oe <= 1'b1;
      channel_ready_out <= 1'b0;
      channel_ready_oe <= 1'b0;
    end else begin
      first_r <= 1'b0;
      mode_r <= gpio_mode;
      if (gpio_dir_load) begin
        dir_r <= gpio_dir_value;
      end
      gpio_in <= {pin28_in, pin27_in};
      // Pin 27 drives only as a GPIO configured for output.
      pin27_out <= gpio_out[0];
      pin27_oe <= gpio_mode & dir_r[0];
      // Pin 28 carries grant 3 unless GPIO mode is selected.
      pin28_out <= gpio_mode ? gpio_out[1] : grant_nxt_n[SBD_SHARED_CH];
      pin28_oe <= gpio_mode ? dir_r[1] : 1'b1;
      // The ready line is only ever sampled; it idles high by pull-up.
      channel_ready_out <= 1'b0;
      channel_ready_oe <= 1'b0;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_rom_select_range: assert property (
    !boot_rom_select_n |-> !dma_cyc_r && rom_hit(side_addr, $past(rom_range_enable)) ||
    st_r != SBD_ST_SETUP)
    else $error("boot ROM select outside an enabled range");
  a_grant_one_hot: assert property (
    $onehot0(~grant_n_r))
    else $error("more than one DMA grant active");
  a_grant_reset_high: assert property (
    first_r |-> &grant_n_r)
    else $error("DMA grant active right after reset");
  a_grant_after_sync: assert property (
    (|(~grant_n_r & $past(grant_n_r))) |-> |($past(req_s2_r) & ~grant_n_r))
    else $error("grant given without a synchronised request");
  a_ready_wait: assert property (
    st_r == SBD_ST_STROBE && cnt_r == 4'h0 && !rdy_s2_r |=>
    st_r == SBD_ST_STROBE && !(io_read_strobe_n && io_write_strobe_n))
    else $error("strobe released while ready low");
  a_strobe_width: assert property (
    $rose(io_read_strobe_n & io_write_strobe_n) && st_r == SBD_ST_HOLD |->
    $past(rdy_s2_r) && $past(cnt_r) == 4'h0)
    else $error("strobe ended early or without ready");
  a_strobe_reset_high: assert property (
    first_r |-> io_read_strobe_n && io_write_strobe_n)
    else $error("strobe active right after reset");
  a_grant_held: assert property (
    dma_cyc_r && (st_r == SBD_ST_SETUP || st_r == SBD_ST_STROBE) && !mode_r |=>
    $stable(grant_n_r))
    else $error("grant changed inside a transfer cycle");
  a_pin28_mux: assert property (
    !mode_r |-> pin28_oe && pin28_out == grant_n_r[SBD_SHARED_CH])
    else $error("pin 28 does not carry grant 3");
  a_pin27_mux: assert property (
    mode_r |-> grant_n_r[SBD_SHARED_CH])
    else $error("channel 3 granted in GPIO mode");
  a_gpio_default: assert property (
    first_r |-> dir_r == SBD_GPIO_DIR_RESET)
    else $error("GPIO direction not at default");

  c_cpu_read: cover property (st_r == SBD_ST_HOLD && !dma_cyc_r && !wr_r);
  c_wait_write: cover property (st_r == SBD_ST_STROBE && cnt_r == 4'h0 && !rdy_s2_r && wr_r);
  c_dma_burst: cover property (dma_cyc_r && st_r == SBD_ST_HOLD ##1 dma_act);
  c_rom_select: cover property ($fell(boot_rom_select_n));

endmodule

//--- tb/sbd_side_bus_tb.sv
// Self-checking bench for the side bus master.
`timescale 1ns/1ns
module sbd_side_bus_tb;
  import sbd_pkg::*;
  localparam int SC = 3;  // Least strobe width used here.
  typedef struct packed {
    logic wr; logic [23:0] addr; logic [15:0] wd; logic [1:0] en; logic [3:0] wt; logic rom;
  } sbd_row_type;
  sbd_row_type rows [7] = '{
    '{1'b0, 24'h0f1234, 16'h0000, 2'h1, 4'h0, 1'b1}, '{1'b0, 24'h0f1234, 16'h0000, 2'h2, 4'h0, 1'b0},
    '{1'b0, 24'h0e0010, 16'h0000, 2'h2, 4'h0, 1'b1}, '{1'b0, 24'h012345, 16'h0000, 2'h3, 4'h0, 1'b0},
    '{1'b1, 24'h0e00aa, 16'hbeef, 2'h2, 4'h0, 1'b1}, '{1'b0, 24'h000300, 16'h0000, 2'h3, 4'h6, 1'b0},
    '{1'b1, 24'h000301, 16'h12c3, 2'h3, 4'h5, 1'b0}};
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic cyc_valid = 1'b0;
  sbd_cyc_type cyc_req = '0;
  logic [1:0] rom_range_enable = 2'h3;
  logic dma_write = 1'b0;
  logic [7:0] dma_len = 8'h01;
  logic [15:0] dma_wdata = 16'h0000;
  logic gpio_mode = 1'b0;
  logic gpio_dir_load = 1'b0;
  logic [1:0] gpio_dir_value = 2'h0;
  logic [1:0] gpio_out = 2'h0;
  logic [3:0] wt = 4'h0;
  logic [3:0] want = 4'h0;
  logic cyc_done, io_read_strobe_n, io_write_strobe_n, boot_rom_select_n, side_data_bus_oe;
  logic channel_ready_out, channel_ready_oe, pin27_out, pin27_oe, pin28_out, pin28_oe;
  logic [15:0] cyc_rdata, side_data_bus_out, slave_data;
  logic [2:0] dma_grant_n;
  logic [1:0] gpio_in;
  logic [23:0] side_addr;
  logic [3:0] req, gnt;
  logic [7:0] last_byte, sel_cnt;
  logic slave_ready, rom_seen;
  int strb, failures, cmp_count;
  // ==========================================================================
  // Wire resolution and the parties
  // ==========================================================================
  wire logic [15:0] side_data_bus_in = side_data_bus_oe ? side_data_bus_out : slave_data;
  wire logic channel_ready_in = channel_ready_oe ? channel_ready_out : slave_ready;
  wire logic pin27_in = pin27_oe ? pin27_out : req[3];
  wire logic pin28_in = pin28_oe ? pin28_out : 1'b0;
  wire logic [2:0] dma_request = req[2:0];
  assign gnt = {gpio_mode | pin28_out, dma_grant_n};
  sbd_side_bus #(.STROBE_CYC(SC), .LEN_W(8)) u_sbd_side_bus (.clock, .resetn, .cyc_valid,
    .cyc_req, .rom_range_enable, .cyc_done, .cyc_rdata, .dma_write, .dma_len, .dma_wdata,
    .dma_request, .dma_grant_n, .io_read_strobe_n, .io_write_strobe_n, .boot_rom_select_n,
    .side_addr, .side_data_bus_in, .side_data_bus_out, .side_data_bus_oe, .channel_ready_in,
    .channel_ready_out, .channel_ready_oe, .gpio_mode, .gpio_dir_load, .gpio_dir_value,
    .gpio_out, .gpio_in, .pin27_in, .pin27_out, .pin27_oe, .pin28_in, .pin28_out, .pin28_oe);
  sbd_slave_model u_sbd_slave_model (.clock, .resetn, .io_read_strobe_n, .io_write_strobe_n,
    .side_addr, .bus_in(side_data_bus_in), .wait_cyc(wt), .want, .grant_n(gnt), .slave_data,
    .slave_ready, .req_r(req), .last_byte_r(last_byte), .sel_cnt_r(sel_cnt));
  // The clock toggles every half period of 50 ns.
  always #50 clock = ~clock;
  // Strobe width and ROM select are watched on every rising edge.
  always @(posedge clock) begin
    if (!io_read_strobe_n || !io_write_strobe_n) strb++;
    if (!boot_rom_select_n) rom_seen = 1'b1;
  end
  // ==========================================================================
  // Tasks
  // ==========================================================================
  // Compares one value and counts it.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  // Moves to just after the n-th next rising edge.
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #10;
  endtask
  // Runs one processor cycle from a row and checks its outcome.
  task automatic run_row(input sbd_row_type r);
    int k;
    rom_range_enable = r.en;
    wt = r.wt;
    strb = 0;
    rom_seen = 1'b0;
    cyc_req = '{r.wr, r.addr, r.wd};
    cyc_valid = 1'b1;
    k = 0;
    while (cyc_done !== 1'b1 && k < 40) begin
      tick(1);
      k++;
    end
    cyc_valid = 1'b0;
    check(rom_seen, r.rom);
    check(strb >= int'(r.wt) && strb >= SC, 1'b1);
    if (r.wr) check(last_byte, r.wd[7:0]);
    else check(cyc_rdata, r.addr[15:0] ^ 16'h5a5a);
    tick(1);
  endtask
  // Waits, bounded, until the grants are all idle or one is active.
  task automatic wait_gnt(input logic idle);
    int k;
    k = 0;
    while (((gnt === 4'hf) !== idle) && k < 40) begin
      tick(1);
      k++;
    end
  endtask
  // One DMA transfer on a channel; odd channels write.
  task automatic dma_ch(input logic [1:0] ch);
    logic [7:0] s0;
    logic [3:0] e;
    e = ~(4'h1 << ch);
    dma_write = ch[0];
    dma_wdata = 16'h00a0 + 16'(ch);
    want[ch] = 1'b1;
    tick(1);
    want = 4'h0;
    check(gnt, 4'hf);
    wait_gnt(1'b0);
    check(gnt, e);
    s0 = sel_cnt;
    wait_gnt(1'b1);
    check(sel_cnt - s0, 8'h01);
    if (ch[0]) check(last_byte, 8'ha0 + 8'(ch));
    tick(2);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Cuts a hang short well past the expected run length.
  initial begin
    #(3000 * 100);
    failures++;
    stop_test;
  end
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    tick(1);
    check({io_read_strobe_n, io_write_strobe_n, boot_rom_select_n, gnt}, 7'h7f);
    tick(2);
    resetn = 1'b1;
    tick(2);
    $display("test reset done");
    foreach (rows[i]) run_row(rows[i]);
    $display("test cycles done");
    for (int c = 0; c < 4; c++) dma_ch(2'(c));
    want = 4'h6;
    tick(1);
    want = 4'h0;
    wait_gnt(1'b0);
    check(gnt, 4'hd);
    wait_gnt(1'b1);
    wait_gnt(1'b0);
    check(gnt, 4'hb);
    wait_gnt(1'b1);
    $display("test dma done");
    gpio_mode = 1'b1;
    resetn = 1'b0;
    tick(1);
    resetn = 1'b1;
    tick(2);
    check({pin28_oe, pin27_oe}, 2'h2);
    gpio_out = 2'h1;
    want = 4'h8;
    tick(1);
    want = 4'h0;
    tick(5);
    check({pin28_out, gpio_in[0]}, 2'h1);
    check(dma_grant_n, 3'h7);
    gpio_dir_value = 2'h1;
    gpio_dir_load = 1'b1;
    tick(1);
    gpio_dir_load = 1'b0;
    tick(2);
    check({pin28_oe, pin27_oe, pin27_out}, 3'h3);
    check(gpio_in, 2'h1);
    check({channel_ready_oe, channel_ready_out, side_data_bus_oe}, 3'h0);
    $display("test gpio done");
    stop_test;
  end
endmodule

//--- tb/sbd_slave_model.sv
// Far-side model: I/O slave with wait states and four DMA peripherals.
`timescale 1ns/1ns
module sbd_slave_model
  import sbd_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  input wire logic [23:0] side_addr,
  input wire logic [15:0] bus_in,
  input wire logic [3:0] wait_cyc,
  input wire logic [3:0] want,
  input wire logic [3:0] grant_n,
  output logic [15:0] slave_data,
  output logic slave_ready,
  output logic [3:0] req_r,
  output logic [7:0] last_byte_r,
  output logic [7:0] sel_cnt_r
);
  logic rd_q_r;  // Read strobe one cycle ago.
  logic wr_q_r;  // Write strobe one cycle ago.
  logic hold_v_r;  // Read data still held after release.
  logic [3:0] wait_r;  // Wait states still to insert.
  logic [15:0] hold_r;  // Last data driven in a read.
  logic fall;  // A strobe has just fallen.
  assign fall = (rd_q_r && !io_read_strobe_n) || (wr_q_r && !io_write_strobe_n);
  // ==========================================================================
  // Strobe history and read data hold
  // ==========================================================================
  // The data is kept one cycle past release, then the line shows junk.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rd_q_r <= 1'b1;
      wr_q_r <= 1'b1;
      hold_v_r <= 1'b0;
      hold_r <= 16'h0000;
    end else begin
      rd_q_r <= io_read_strobe_n;
      wr_q_r <= io_write_strobe_n;
      hold_v_r <= !io_read_strobe_n;
      if (!io_read_strobe_n) hold_r <= slave_data;
    end
  end
  assign slave_data = !io_read_strobe_n ? (side_addr[15:0] ^ 16'h5a5a) :
                      (hold_v_r ? hold_r : ~hold_r);
  // Wait counter loaded as a strobe falls; the ready line idles high.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wait_r <= 4'h0;
    end else if (fall) begin
      wait_r <= wait_cyc;
    end else if (wait_r != 4'h0) begin
      wait_r <= wait_r - 4'h1;
    end
  end
  // Ready drops in the same cycle as the strobe falls, so that the master's
  // two synchroniser stages see it before the least strobe width has run.
  assign slave_ready = (wait_r == 4'h0) && !(fall && wait_cyc != 4'h0);
  // Low byte taken as the write strobe rises; selections counted per grant.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      last_byte_r <= 8'h00;
      sel_cnt_r <= 8'h00;
    end else begin
      if (!wr_q_r && io_write_strobe_n) last_byte_r <= bus_in[7:0];
      if (fall && grant_n != 4'hf) sel_cnt_r <= sel_cnt_r + 8'h01;
    end
  end
  // Each request is held until its grant is seen low.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      req_r <= 4'h0;
    end else begin
      req_r <= (req_r | want) & grant_n;
    end
  end
endmodule
